// *** hw/cca_axil_slave.sv ***
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the parent answers rdData combinationally from s_axi_araddr.
`timescale 1ns/1ns
`default_nettype none
module cca_axil_slave (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] rdData,
	output cca_pkg::cca_wreq_t wreq
);
	logic awHeld, wHeld;
	logic [7:0] addr;
	logic [31:0] data;
	logic [3:0] strb;
	logic next_awHeld, next_wHeld, next_bvalid, next_awready, next_wready;
	logic next_arready, next_rvalid;
	logic [7:0] next_addr;
	logic [31:0] next_data, next_rdata;
	logic [3:0] next_strb;
	logic [1:0] next_bresp, next_rresp;
	logic doWrite;

	// Address and data are taken in either order; the write fires once both are held
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign wreq = '{en: doWrite, addr: addr, data: data, strb: strb};

	always_comb begin
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_addr = addr;
		next_data = data;
		next_strb = strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_data = s_axi_wdata;
			next_strb = s_axi_wstrb;
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = cca_pkg::cca_reg_hit(addr) ? cca_pkg::RESP_OKAY : cca_pkg::RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_awHeld && !next_bvalid;
		next_wready = !next_wHeld && !next_bvalid;
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = rdData;
			next_rresp = cca_pkg::cca_reg_hit(s_axi_araddr) ? cca_pkg::RESP_OKAY : cca_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end else if (!s_axi_rvalid) begin
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			addr <= 8'h00;
			data <= 32'h0000_0000;
			strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			addr <= next_addr;
			data <= next_data;
			strb <= next_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
endmodule
`default_nettype wire

// *** hw/cca_frame_align.sv ***
// Control-channel clock and frame alignment, with VCO phase-detector output.
// Assumes mclk acts as the master clock; bit clock, frame sync and data arrive as pins.
//
// Operation
// RL1: VCO control is bit clock XOR master/4
// RL2: Invert bit flips the VCO control output
// RL3: External loop keeps phase within 0..180 degrees
// RL4: Monitor pin shows master/4 delayed three cycles
// RL5: Far side supplies 4 ms multiframe sync
// RL6: Frame position loaded from offset registers at sync
// RL7: Bit phase from two top offset bits
// RL8: Alignment refers to falling bit clock edge
// RL9: Edge select clear: sample and sync falling
// RL10: Edge select set: sample rising, sync next falling
// RL11: Inputs sampled at start of phase two
// RL12: Output and drive launched at phase zero
// RL13: Start register numbers first complete frame
// RL14: Own sync output never replaces sync input
// RL15: Frame counter wraps after thirty-two frames
`timescale 1ns/1ns
`default_nettype none
module cca_frame_align (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic systemBitClockIn,
	input wire logic frameSyncInN,
	input wire logic monitorSelectPin,
	input wire logic channelDataIn,
	input wire logic txBit,
	input wire logic txDrive,
	output logic vcoControlOut,
	output logic monitorClockOut,
	output logic channelDataOut,
	output logic channelDriveN,
	output logic rxBit,
	output logic rxStrobe,
	output logic aligned,
	output cca_pkg::cca_pos_t pos
);
	// -------------------------------
	// Pin synchronisers
	// -------------------------------
	logic bclkS, fsNS, monSelS, dataInS;

	cca_sync2 #(.WIDTH(4)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.asyncIn({systemBitClockIn, frameSyncInN, monitorSelectPin, channelDataIn}),
		.syncOut({bclkS, fsNS, monSelS, dataInS})
	);

	// -------------------------------
	// Register bus
	// -------------------------------
	cca_pkg::cca_wreq_t wreq;
	logic [31:0] rdData;
	logic cfgInvert, cfgEdge;
	logic [7:0] frameOfs, phaseOfs;
	logic [4:0] mfStart;
	logic next_cfgInvert, next_cfgEdge, rearm;
	logic [7:0] next_frameOfs, next_phaseOfs;
	logic [4:0] next_mfStart;

	cca_axil_slave u_bus (
		.mclk(mclk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rdData(rdData),
		.wreq(wreq)
	);

	always_comb begin
		next_cfgInvert = cfgInvert;
		next_cfgEdge = cfgEdge;
		next_frameOfs = frameOfs;
		next_mfStart = mfStart;
		next_phaseOfs = phaseOfs;
		rearm = 1'b0;
		// Every field sits in byte lane 0
		if (wreq.en && wreq.strb[0]) begin
			case (wreq.addr)
				cca_pkg::REG_CONFIG: begin
					next_cfgInvert = wreq.data[cca_pkg::CFG_INVERT_BIT];
					next_cfgEdge = wreq.data[cca_pkg::CFG_EDGE_BIT];
					rearm = wreq.data[cca_pkg::CFG_REARM_BIT];
				end
				cca_pkg::REG_FRAME_OFS: next_frameOfs = wreq.data[7:0];
				cca_pkg::REG_MF_START: next_mfStart = wreq.data[4:0];
				cca_pkg::REG_PHASE_OFS: next_phaseOfs = wreq.data[7:0];
				default: rearm = 1'b0;
			endcase
		end
		case (s_axi_araddr)
			cca_pkg::REG_CONFIG: rdData = {30'h0000_0000, cfgEdge, cfgInvert};
			cca_pkg::REG_FRAME_OFS: rdData = {24'h00_0000, frameOfs};
			cca_pkg::REG_MF_START: rdData = {27'h000_0000, mfStart};
			cca_pkg::REG_PHASE_OFS: rdData = {24'h00_0000, phaseOfs};
			cca_pkg::REG_STATUS: rdData = {16'h0000, aligned, pos};
			default: rdData = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfgInvert <= 1'b0;
			cfgEdge <= 1'b0;
			frameOfs <= cca_pkg::RST_FRAME_OFS;
			mfStart <= cca_pkg::RST_MF_START;
			phaseOfs <= cca_pkg::RST_PHASE_OFS;
		end else begin
			cfgInvert <= next_cfgInvert;
			cfgEdge <= next_cfgEdge;
			frameOfs <= next_frameOfs;
			mfStart <= next_mfStart;
			phaseOfs <= next_phaseOfs;
		end
	end

	// -------------------------------
	// Divider, phase detector, monitor
	// -------------------------------
	localparam int MON_DLY_W = cca_pkg::MON_DELAY - 1;
	logic [1:0] divCnt;
	logic [MON_DLY_W-1:0] dlyLine;
	logic [1:0] next_divCnt;
	logic [MON_DLY_W-1:0] next_dlyLine;
	logic next_vco, next_mon, intClk;

	assign intClk = divCnt[1];

	always_comb begin
		next_divCnt = 2'(divCnt + 2'h1); // [RL1]
		next_dlyLine = {dlyLine[MON_DLY_W-2:0], intClk};
		// Only the bit clock carries the two-flop synchroniser lag; the divided clock enters the XOR directly
		next_vco = bclkS ^ intClk ^ cfgInvert; // [RL1] [RL2]
		// Output flop supplies the last of the three cycles
		next_mon = monSelS ? dlyLine[MON_DLY_W-1] : 1'b0; // [RL4]
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			divCnt <= 2'h0;
			dlyLine <= '0;
			vcoControlOut <= 1'b0;
			monitorClockOut <= 1'b0;
		end else begin
			divCnt <= next_divCnt;
			dlyLine <= next_dlyLine;
			vcoControlOut <= next_vco;
			monitorClockOut <= next_mon;
		end
	end

	// -------------------------------
	// Frame sync and position counters
	// -------------------------------
	logic bclkPrev, syncPending, fallEdge, riseEdge, syncPoint, startsFrame;
	logic next_syncPending, next_aligned, next_rxStrobe, next_rxBit, next_dataOut, next_driveN;
	cca_pkg::cca_pos_t loadPos, stepPos, next_pos;

	assign fallEdge = bclkPrev && !bclkS;
	assign riseEdge = !bclkPrev && bclkS;
	// Falling edge is always the reference point for alignment
	assign syncPoint = fallEdge && ((!cfgEdge && !fsNS) || (cfgEdge && syncPending)); // [RL8] [RL9] [RL10]

	always_comb begin
		loadPos.phase = phaseOfs[7:6]; // [RL7]
		loadPos.chan = frameOfs[7:3]; // [RL6]
		loadPos.bitNo = frameOfs[2:0];
		startsFrame = loadPos.phase == cca_pkg::LAUNCH_PHASE && loadPos.bitNo == cca_pkg::BIT_FIRST &&
			loadPos.chan == cca_pkg::CHAN_FIRST;
		// A partial frame at sync is not counted; the next full one gets the start number
		loadPos.frame = startsFrame ? mfStart : 5'(mfStart - 5'h01); // [RL13]
		stepPos = pos;
		stepPos.phase = 2'(pos.phase + 2'h1);
		if (pos.phase == cca_pkg::PHASE_LAST) begin
			stepPos.bitNo = 3'(pos.bitNo - 3'h1);
			if (pos.bitNo == cca_pkg::BIT_LAST) begin
				stepPos.chan = 5'(pos.chan + 5'h01);
				if (pos.chan == cca_pkg::CHAN_LAST) begin
					stepPos.frame = 5'(pos.frame + 5'h01); // [RL15]
				end
			end
		end
		next_pos = pos;
		next_aligned = aligned;
		next_syncPending = syncPending;
		next_rxStrobe = 1'b0;
		next_rxBit = rxBit;
		next_dataOut = channelDataOut;
		next_driveN = channelDriveN;
		// Re-arm first, so a sync landing in the same cycle still counts as the first when the block was not yet aligned
		if (rearm) begin
			next_aligned = 1'b0;
			next_syncPending = 1'b0;
			next_driveN = 1'b1;
		end
		if (riseEdge && cfgEdge && !fsNS && !aligned) begin
			next_syncPending = 1'b1; // [RL10]
		end
		if (fallEdge) begin
			if (!aligned && syncPoint) begin
				next_pos = loadPos; // [RL6]
				next_aligned = 1'b1;
				next_syncPending = 1'b0;
			end else if (aligned) begin
				next_pos = stepPos;
			end
			if (next_aligned && next_pos.phase == cca_pkg::SAMPLE_PHASE) begin
				next_rxBit = dataInS; // [RL11]
				next_rxStrobe = 1'b1;
			end
			if (next_aligned && next_pos.phase == cca_pkg::LAUNCH_PHASE) begin
				next_dataOut = txBit; // [RL12]
				next_driveN = !txDrive;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bclkPrev <= 1'b0;
			syncPending <= 1'b0;
			aligned <= 1'b0;
			pos <= '0;
			rxStrobe <= 1'b0;
			rxBit <= 1'b0;
			channelDataOut <= 1'b0;
			channelDriveN <= 1'b1;
		end else begin
			bclkPrev <= bclkS;
			syncPending <= next_syncPending;
			aligned <= next_aligned;
			pos <= next_pos;
			rxStrobe <= next_rxStrobe;
			rxBit <= next_rxBit;
			channelDataOut <= next_dataOut;
			channelDriveN <= next_driveN;
		end
	end

	// -------------------------------
	// Assertions
	// -------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	div_quarter_a: assert property ($rose(intClk) |-> intClk [*2] ##1 !intClk [*2]) // [RL1]
		else $error("internal bit clock is not master divided by four");
	vco_xor_a: assert property (##1 vcoControlOut == ($past(bclkS) ^ $past(intClk) ^ $past(cfgInvert))) // [RL1] [RL2]
		else $error("vco control is not bit clock xor divided clock");
	mon_delay_a: assert property ($past(monSelS) |-> monitorClockOut == $past(intClk, 3)) // [RL4]
		else $error("monitor clock not divided clock delayed three cycles");
	mon_off_a: assert property (!$past(monSelS) |-> !monitorClockOut) // [RL4]
		else $error("monitor clock driven while not selected");
	fall_sync_a: assert property (fallEdge && !fsNS && !cfgEdge && !aligned && !rearm |=> aligned) // [RL9]
		else $error("falling-edge sync did not align");
	rise_sync_a: assert property (riseEdge && !fsNS && cfgEdge && !aligned && !rearm |=> !aligned && syncPending) // [RL10]
		else $error("rising-edge sync aligned before the next falling edge");
	load_pos_a: assert property ($rose(aligned) |-> pos.phase == $past(phaseOfs[7:6]) && // [RL7]
		pos.chan == $past(frameOfs[7:3]) && $past(fallEdge))
		else $error("alignment position not loaded from offsets");
	mf_start_a: assert property ($rose(aligned) && // [RL13]
		!(pos.phase == 2'h0 && pos.bitNo == 3'h7 && pos.chan == 5'h00) |->
		pos.frame == 5'($past(mfStart) - 5'h01))
		else $error("partial first frame not numbered before start value");
	sample_phase_a: assert property (rxStrobe |-> pos.phase == 2'h2 && $past(fallEdge)) // [RL11]
		else $error("input sampled outside phase two");
	launch_phase_a: assert property (aligned && $past(aligned) && $changed(channelDataOut) |-> // [RL12]
		pos.phase == 2'h0)
		else $error("output launched outside phase zero");
	frame_wrap_a: assert property (aligned && $past(aligned) && $changed(pos.frame) |-> // [RL15]
		pos.frame == 5'($past(pos.frame) + 5'h01) && $past(pos.chan) == 5'h1F)
		else $error("frame counter did not step or wrap modulo thirty-two");
endmodule
`default_nettype wire

// *** hw/cca_pkg.sv ***
// Constants, register map and carrier types for the control-channel alignment block.
// Assumes a single 100 MHz clock that stands in for the master clock.
`default_nettype none
package cca_pkg;
	// ---------------------------------------------
	// Register map (byte addresses, one word each)
	// ---------------------------------------------
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_FRAME_OFS = 8'h04;
	localparam logic [7:0] REG_MF_START = 8'h08;
	localparam logic [7:0] REG_PHASE_OFS = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int CFG_INVERT_BIT = 0;
	localparam int CFG_EDGE_BIT = 1;
	localparam int CFG_REARM_BIT = 2;
	localparam logic [7:0] RST_FRAME_OFS = 8'h00;
	localparam logic [4:0] RST_MF_START = 5'h00;
	localparam logic [7:0] RST_PHASE_OFS = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ---------------------------------------------
	// Timing and framing
	// ---------------------------------------------
	localparam int MCLK_DIV = 4;
	localparam int MON_DELAY = 3;
	localparam logic [1:0] SAMPLE_PHASE = 2'h2;
	localparam logic [1:0] LAUNCH_PHASE = 2'h0;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [2:0] BIT_FIRST = 3'h7;
	localparam logic [2:0] BIT_LAST = 3'h0;
	localparam logic [4:0] CHAN_FIRST = 5'h00;
	localparam logic [4:0] CHAN_LAST = 5'h1F;
	// ---------------------------------------------
	// Types
	// ---------------------------------------------
	typedef struct packed {
		logic [4:0] frame;
		logic [4:0] chan;
		logic [2:0] bitNo;
		logic [1:0] phase;
	} cca_pos_t;
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} cca_wreq_t;
	function automatic logic cca_reg_hit(input logic [7:0] addr);
		return addr == REG_CONFIG || addr == REG_FRAME_OFS || addr == REG_MF_START ||
			addr == REG_PHASE_OFS || addr == REG_STATUS;
	endfunction
endpackage
`default_nettype wire

// *** hw/cca_sync2.sv ***
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to mclk; no logic reads the first stage.
`timescale 1ns/1ns
`default_nettype none
module cca_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_syncOut;

	always_comb begin
		next_stage1 = asyncIn;
		next_syncOut = stage1;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			stage1 <= '0;
			syncOut <= '0;
		end else begin
			stage1 <= next_stage1;
			syncOut <= next_syncOut;
		end
	end
endmodule
`default_nettype wire

// *** test/cca_line_partner.sv ***
// Line-side model: bit clock locked to mclk/4, frame sync and serial data.
// Assumes the bench resets it together with the design and gates sync with syncEn.
`timescale 1ns/1ns
`default_nettype none
module cca_line_partner #(
	parameter int SYNC_BITS = 64
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic syncEn,
	output logic bitClk,
	output logic syncN,
	output logic data
);
	logic [1:0] cnt, next_cnt;
	logic [7:0] bitIdx, next_bitIdx;
	logic next_bitClk, next_syncN, next_data;
	logic syncWin;
	// ------------------
	// Line timing
	// ------------------
	always_comb begin
		next_cnt = cnt + 2'h1;
		next_bitIdx = bitIdx;
		if (cnt == 2'h3)
			next_bitIdx = (bitIdx == 8'(SYNC_BITS - 1)) ? 8'h00 : bitIdx + 8'h01;
		// Four mclk per bit keeps a fixed phase to the internal clock
		next_bitClk = next_cnt < 2'h2;
		// Low over one falling and the next rising edge; multiframe shortened
		syncWin = (next_bitIdx == 8'h00 && next_cnt != 2'h0) || (next_bitIdx == 8'h01 && next_cnt == 2'h0);
		// Own line-side sync only, never one looped back from the device
		next_syncN = !(syncEn && syncWin);
		next_data = (next_cnt == 2'h2) ? next_bitIdx[0] ^ next_bitIdx[2] : data;
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt <= 2'h0;
			bitIdx <= 8'h00;
			bitClk <= 1'b1;
			syncN <= 1'b1;
			data <= 1'b0;
		end else begin
			cnt <= next_cnt;
			bitIdx <= next_bitIdx;
			bitClk <= next_bitClk;
			syncN <= next_syncN;
			data <= next_data;
		end
	end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the control-channel alignment block.
// Assumes the package, design files and line partner model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic systemBitClockIn, frameSyncInN, channelDataIn;
	logic monitorSelectPin = 1'b0, txBit = 1'b0, txDrive = 1'b0, syncEn = 1'b0;
	logic vcoControlOut, monitorClockOut, channelDataOut, channelDriveN, rxBit, rxStrobe, aligned;
	cca_pkg::cca_pos_t pos, prevPos;
	int n_fail = 0, num_checks = 0, cyc = 0, syncT = 0, lastDel = 0, stepCnt = 0, invCnt = 0, selCnt = 0;
	int dl[2];
	logic [7:0] fo = 8'h00, po = 8'h00;
	logic [4:0] mf = 5'h00;
	logic inv = 1'b0, invPrev = 1'b0, invFlip = 1'b0, selPrev = 1'b0, prevAl = 1'b0, prevSyncN = 1'b1;
	logic [1:0] lastTx = 2'h0, prevOut = 2'h1, mh = 2'h0;
	logic [15:0] vh = 16'h0;
	logic [2:0] dh = 3'h0;
	always #5 mclk = ~mclk;
	cca_line_partner #(.SYNC_BITS(64)) u_line (.mclk, .rst, .syncEn, .bitClk(systemBitClockIn),
		.syncN(frameSyncInN), .data(channelDataIn));
	cca_frame_align DUT (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .systemBitClockIn, .frameSyncInN, .monitorSelectPin, .channelDataIn, .txBit,
		.txDrive, .vcoControlOut, .monitorClockOut, .channelDataOut, .channelDriveN, .rxBit, .rxStrobe,
		.aligned, .pos);
	// ------------------
	// Checking helpers
	// ------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic results();
		$display("checks=%0d mismatches=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic cca_pkg::cca_pos_t exp_load(input logic [7:0] f, input logic [4:0] m, input logic [7:0] p);
		cca_pkg::cca_pos_t q;
		q.phase = p[7:6];
		q.chan = f[7:3];
		q.bitNo = f[2:0];
		q.frame = m - 5'h01;
		if (q.phase == 2'h0 && q.bitNo == cca_pkg::BIT_FIRST && q.chan == cca_pkg::CHAN_FIRST)
			q.frame = m;
		return q;
	endfunction
	function automatic cca_pkg::cca_pos_t step(input cca_pkg::cca_pos_t p);
		cca_pkg::cca_pos_t q;
		q = p;
		q.phase = p.phase + 2'h1;
		if (p.phase == 2'h3)
			q.bitNo = p.bitNo - 3'h1;
		if (p.phase == 2'h3 && p.bitNo == 3'h0)
			q.chan = p.chan + 5'h01;
		if (p.phase == 2'h3 && p.bitNo == 3'h0 && p.chan == 5'h1F)
			q.frame = p.frame + 5'h01;
		return q;
	endfunction
	// ------------------
	// AXI4-Lite master
	// ------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done && n < 200) begin
			@(posedge mclk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				done = 1;
				s_axi_bready <= 1'b0;
			end
		end
		chk(32'(done), 32'h1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done && n < 200) begin
			@(posedge mclk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				done = 1;
				s_axi_rready <= 1'b0;
			end
		end
		chk(32'(done), 32'h1);
	endtask
	// Offsets first, re-arm last, so a realignment never sees half a setup
	task automatic setup(input logic s, input logic i, input logic [7:0] f, input logic [4:0] m, input logic [7:0] p);
		logic [1:0] r;
		logic [31:0] d, c;
		fo = f;
		mf = m;
		po = p;
		c = (32'(s) << cca_pkg::CFG_EDGE_BIT) | (32'(i) << cca_pkg::CFG_INVERT_BIT);
		wr(cca_pkg::REG_FRAME_OFS, 32'(f), r);
		wr(cca_pkg::REG_MF_START, 32'(m), r);
		wr(cca_pkg::REG_PHASE_OFS, 32'(p), r);
		wr(cca_pkg::REG_CONFIG, c | (32'h1 << cca_pkg::CFG_REARM_BIT), r);
		inv = i;
		rd(cca_pkg::REG_FRAME_OFS, d, r);
		chk(d, 32'(f));
		rd(cca_pkg::REG_MF_START, d, r);
		chk(d, 32'(m));
		rd(cca_pkg::REG_PHASE_OFS, d, r);
		chk(d, 32'(p));
		rd(cca_pkg::REG_CONFIG, d, r);
		chk(d, c);
	endtask
	// ------------------
	// Port monitor
	// ------------------
	always @(posedge mclk) begin
		txBit <= 1'($urandom);
		txDrive <= 1'($urandom);
	end
	always @(posedge mclk) begin
		cyc++;
		if (!frameSyncInN && prevSyncN)
			syncT = cyc;
		if (aligned && !prevAl) begin
			lastDel = cyc - syncT;
			chk(32'(pos), 32'(exp_load(fo, mf, po)));
			stepCnt = 1;
		end else if (aligned && prevAl) begin
			if (pos !== prevPos) begin
				chk(32'(pos), 32'(step(prevPos)));
				chk(stepCnt, 4);
				stepCnt = 1;
			end else
				stepCnt++;
			if (rxStrobe || (pos !== prevPos && pos.phase == cca_pkg::SAMPLE_PHASE))
				chk(32'({rxStrobe, pos.phase}), 32'({1'b1, cca_pkg::SAMPLE_PHASE}));
			chk(32'({channelDataOut, channelDriveN}), 32'((pos !== prevPos && pos.phase == cca_pkg::LAUNCH_PHASE) ?
				{lastTx[1], !lastTx[0]} : prevOut));
		end
		if (inv != invPrev) begin
			invCnt = 0;
			invFlip = 1'b1;
		end else if (invCnt < 99)
			invCnt++;
		if (invCnt == 12 && invFlip)
			chk(32'(vcoControlOut), 32'(!vh[15]));
		if (invCnt > 20)
			chk(32'(vcoControlOut), 32'(vh[1]));
		if (monitorSelectPin != selPrev)
			selCnt = 0;
		else if (selCnt < 99)
			selCnt++;
		if (selCnt > 8)
			chk(32'(monitorClockOut), 32'(monitorSelectPin && !mh[1]));
		// Sampled bit is the data pin three edges back: two sync flops plus the capture flop
		if (rxStrobe)
			chk(32'(rxBit), 32'(dh[2]));
		dh = {dh[1:0], channelDataIn};
		vh = {vh[14:0], vcoControlOut};
		mh = {mh[0], monitorClockOut};
		prevPos = pos;
		prevAl = aligned;
		prevSyncN = frameSyncInN;
		prevOut = {channelDataOut, channelDriveN};
		lastTx = {txBit, txDrive};
		invPrev = inv;
		selPrev = monitorSelectPin;
	end
	// ------------------
	// Main sequence
	// ------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int n;
		d = $urandom(21461);
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd(cca_pkg::REG_MF_START, d, r);
		chk(d, 32'(cca_pkg::RST_MF_START));
		rd(8'h14, d, r);
		chk({d[29:0], r}, 32'(cca_pkg::RESP_SLVERR));
		wr(8'h14, 32'h5A, r);
		chk(32'(r), 32'(cca_pkg::RESP_SLVERR));
		for (int k = 0; k < 4; k++) begin
			monitorSelectPin <= 1'($urandom);
			if (k == 0)
				setup(1'b0, 1'b0, 8'hF8, 5'h00, 8'hC0);
			else
				setup(k[0], k[1], 8'($urandom), 5'($urandom), 8'($urandom));
			syncEn <= 1'b1;
			n = 0;
			while (!aligned && n < 2000) begin
				@(posedge mclk);
				n++;
			end
			chk(32'(aligned), 32'h1);
			repeat (300) @(posedge mclk);
			rd(cca_pkg::REG_STATUS, d, r);
			chk(32'(d[15]), 32'h1);
			dl[k % 2] = lastDel;
		end
		chk(32'(dl[1] - dl[0]), 32'h4);
		results();
	end
	initial begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		results();
	end
endmodule
`default_nettype wire
